// ===== cmbf_bytecmp.sv
module cmbf_bytecmp
  import cmbf_pkg::*;
(
  input  wire cmbf_pkg::cmbf_byte_t pattern,
  input  wire cmbf_pkg::cmbf_byte_t mask,
  input  wire cmbf_pkg::cmbf_byte_t data,
  output wire logic                 match
);
  // a set mask bit makes that bit a don't-care
  assign match = &(~(pattern ^ data) | mask);
endmodule

// ===== cmbf_can_model.sv
module cmbf_can_model
  import cmbf_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic [1:0]            tx_sel,
  input  wire logic [7:0]            tx_rd_data,
  output logic                       rx_wr_en,
  output cmbf_pkg::cmbf_rx_wr_t      rx_wr,
  output logic                       rx_eof,
  output logic                       rx_own,
  output logic                       tx_arb,
  output logic                       tx_done,
  output logic                       tx_fail,
  output logic      [3:0]            tx_rd_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {rx_wr_en, rx_wr, rx_eof, rx_own, tx_arb, tx_done, tx_fail, tx_rd_idx} = '0;
  end
  // own counts bytes sent while still owning the bus
  task automatic rx_frame(input logic [103:0] f, input int own);
    for (int i = 0; i < BUF_BYTES; i++)
    begin
      @(posedge mclk);
      rx_wr_en <= 1'b1;
      rx_wr    <= '{idx: i[3:0], data: f[8*i+:8]};
      rx_own   <= (i < own);
    end
    @(posedge mclk);
    rx_wr_en   <= 1'b0;
    rx_eof     <= 1'b1;
    rx_wr.data <= ~rx_wr.data;
    @(posedge mclk);
    rx_eof <= 1'b0;
    rx_own <= 1'b0;
  endtask
  task automatic tx_run(input logic ok, input int gap, output logic [1:0] sel,
                        output logic [7:0] b0);
    @(posedge mclk);
    tx_arb <= 1'b1;
    @(posedge mclk);
    tx_arb    <= 1'b0;
    tx_rd_idx <= 4'h0;
    @(posedge mclk);
    #1;
    sel = tx_sel;
    b0  = tx_rd_data;
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    tx_done   <= ok;
    tx_fail   <= !ok;
    tx_rd_idx <= 4'hf;
    @(posedge mclk);
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
  endtask
endmodule

// ===== cmbf_core.sv
// Operation
// (RULE_01) received frames go through background then foreground buffer, one window
// (RULE_02) each receive buffer holds 13 bytes: control, identifier, data
// (RULE_03) rx full flag set when foreground holds an accepted good frame
// (RULE_04) filter checked while background fills; accepted frame copied if flag clear
// (RULE_05) software reads foreground then clears rx full flag
// (RULE_06) background overwritten by next frame whatever the filter says
// (RULE_07) receive interrupt only when enabled; flag stays pollable
// (RULE_08) own frame goes to background only; no copy, interrupt or ack
// (RULE_09) loop-back treats own frames as ordinary received frames
// (RULE_10) lost arbitration turns the node into a normal receiver
// (RULE_11) accepted frame with foreground full is dropped, overrun flagged; tx continues
// (RULE_12) three 13-byte transmit buffers, each with 8-bit local priority
// (RULE_13) software fills an empty buffer then clears its empty flag
// (RULE_14) successful send sets empty flag; tx interrupt unless masked
// (RULE_15) each arbitration picks ready buffer with lowest priority value
// (RULE_16) abort granted only if not on bus; sets ack and empty flag
// (RULE_17) pattern gives expected id bits; set mask bits are ignored
// (RULE_18) two-bit hit index records lowest matching filter
// (RULE_19) 32-bit mode: full extended id with srr ide rtr, or standard
// (RULE_20) dual 16-bit mode: top 14 extended bits with srr ide, or standard
// (RULE_21) quad mode: four filters compare first eight id bits
// (RULE_22) closed mode never copies a frame nor sets rx full
// (RULE_23) receive interrupt raised right after end of frame
// (RULE_24) flags clear by writing one; a pending cause keeps them set
// (RULE_25) two-bit mode field in acceptance control selects filter mode
module cmbf_core
  import cmbf_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic      [31:0]          hrdata,
  output logic                      hresp,
  input  wire logic                 rx_wr_en,
  input  wire cmbf_pkg::cmbf_rx_wr_t rx_wr,
  input  wire logic                 rx_eof,
  input  wire logic                 rx_own,
  input  wire logic                 tx_arb,
  input  wire logic                 tx_done,
  input  wire logic                 tx_fail,
  input  wire logic [3:0]           tx_rd_idx,
  output logic                      tx_pending,
  output logic      [1:0]           tx_sel,
  output logic      [7:0]           tx_rd_data,
  output logic                      rx_ack_en,
  output logic                      loopback,
  output logic                      rx_irq,
  output logic                      tx_irq,
  output logic                      err_irq
);

  cmbf_bus_state_t    bus_q;
  logic [7:0]         addr_q;
  logic               wr_q;
  logic               hreadyout_q;
  logic [31:0]        hrdata_q;

  cmbf_byte_t         bg_q  [BUF_BYTES];
  cmbf_byte_t         fg_q  [BUF_BYTES];
  cmbf_byte_t         txb_q [NUM_TXB][BUF_BYTES];
  logic [NUM_TXB*BYTE_W-1:0] local_priority_field_q;

  logic               rxf_q;
  logic               ovr_q;
  logic               rxie_q;
  logic               ovrie_q;
  logic [NUM_TXB-1:0] txe_q;
  logic [NUM_TXB-1:0] abort_acknowledge_bit_q;
  logic [NUM_TXB-1:0] abort_request_bit_q;
  logic [NUM_TXB-1:0] txie_q;
  logic [1:0]         mode_q;
  logic [1:0]         hit_q;
  logic               loop_q;
  logic [31:0]        pat_q;
  logic [31:0]        msk_q;
  logic               tx_busy_q;
  logic [1:0]         tx_sel_q;
  logic               tx_pending_q;
  logic [7:0]         tx_rd_data_q;
  logic               rx_ack_en_q;
  logic               rx_irq_q;
  logic               tx_irq_q;
  logic               err_irq_q;

  // ---------------- bus decode
  wire                acc_take  = hsel & htrans[1] & hready;
  wire                wr_fire   = (bus_q == BUS_DATA) & wr_q;
  wire  [2:0]         region    = addr_q[7:5];
  wire  [2:0]         word      = addr_q[4:2];
  wire  [1:0]         tx_n      = addr_q[6:5];
  wire                is_ctrl   = region == REG_CTRL;
  wire                is_fg     = region == REG_RX_FG;
  wire                is_tx     = addr_q[7] & (tx_n != TX_NONE);
  wire                wr_rxflag = wr_fire & (addr_q == OFS_RX_FLAG);
  wire                wr_rxie   = wr_fire & (addr_q == OFS_RX_IE);
  wire                wr_txflag = wr_fire & (addr_q == OFS_TX_FLAG);
  wire                wr_txctrl = wr_fire & (addr_q == OFS_TX_CTRL);
  wire                wr_acc    = wr_fire & (addr_q == OFS_ACC_CTRL);
  wire                wr_pat    = wr_fire & (addr_q == OFS_PATTERN);
  wire                wr_msk    = wr_fire & (addr_q == OFS_MASK);
  wire                wr_txdata = wr_fire & is_tx & (word < DATA_WORDS);
  wire                wr_txprio = wr_fire & is_tx & (word == LOCAL_PRIORITY_FIELD_WORD);

  // ---------------- acceptance filter
  wire cmbf_byte_t    cmp_data [NUM_FILT];
  wire  [NUM_FILT-1:0] bm;
  wire                ide = bg_q[1][IDE_BIT];

  for (genvar g = 0; g < NUM_FILT; g++)
  begin : g_filt
    // byte routing per mode: first four bytes, first two bytes, or first byte only
    assign cmp_data[g] = (mode_q == FM_32) ? bg_q[g] :              // RULE_19
                         (mode_q == FM_16) ? bg_q[g % 2] : bg_q[0]; // RULE_20 RULE_21
    cmbf_bytecmp u_cmp (
      .pattern (pat_q[g*BYTE_W +: BYTE_W]),
      .mask    (msk_q[g*BYTE_W +: BYTE_W]),
      .data    (cmp_data[g]),
      .match   (bm[g])
    ); // RULE_17
  end

  // standard frames end after the second identifier byte
  wire                h32  = bm[0] & bm[1] & (~ide | (bm[2] & bm[3])); // RULE_19
  wire  [NUM_FILT-1:0] hits =
    (mode_q == FM_32) ? {3'b000, h32} :                        // RULE_19
    (mode_q == FM_16) ? {2'b00, bm[2] & bm[3], bm[0] & bm[1]} : // RULE_20
    (mode_q == FM_8)  ? bm : '0;                               // RULE_21 RULE_22 RULE_25
  wire  [1:0]         hit_idx = hits[0] ? 2'h0 :
                                hits[1] ? 2'h1 :
                                hits[2] ? 2'h2 : 2'h3; // RULE_18
  // own frames only count in loop-back; after lost arbitration rx_own drops
  wire                own_ok  = ~rx_own | loop_q; // RULE_08 RULE_09 RULE_10
  wire                accept  = rx_eof & (|hits) & own_ok; // RULE_04
  wire                rxf_clr = wr_rxflag & hwdata[RXF_BIT];
  wire                ovr_clr = wr_rxflag & hwdata[OVR_BIT];
  wire                fg_free = ~rxf_q | rxf_clr;
  wire                rx_copy = accept & fg_free; // RULE_04
  wire                ovr_set = accept & ~fg_free; // RULE_11

  // ---------------- transmit scheduling
  wire  [NUM_TXB-1:0] onbus   = tx_busy_q ? NUM_TXB'(1) << tx_sel_q : '0;
  wire  [NUM_TXB-1:0] ready_v = ~txe_q & ~abort_request_bit_q;
  wire  [NUM_TXB-1:0] abt_ok  = abort_request_bit_q & ~txe_q & ~onbus; // RULE_16
  wire  [NUM_TXB-1:0] sent    = tx_done ? onbus : '0; // RULE_14
  wire  [NUM_TXB-1:0] txe_clr = wr_txflag ? hwdata[TXE_LSB +: NUM_TXB] : '0;
  wire  [1:0]         pick_sel;
  wire                pick_any;

  cmbf_local_priority_field_pick u_pick (
    .ready (ready_v),
    .local_priority_field  (local_priority_field_q),
    .sel   (pick_sel),
    .any   (pick_any)
  );

  // ---------------- read mux
  logic [31:0]        rd_mux;
  int                 idx;

  always_comb
  begin
    rd_mux = '0;
    idx    = 0;
    if (is_ctrl)
    begin
      unique case (addr_q)
        OFS_RX_FLAG:
        begin
          rd_mux[RXF_BIT] = rxf_q; // RULE_07
          rd_mux[OVR_BIT] = ovr_q;
        end
        OFS_RX_IE:
        begin
          rd_mux[RXF_BIT] = rxie_q;
          rd_mux[OVR_BIT] = ovrie_q;
        end
        OFS_TX_FLAG:
        begin
          rd_mux[TXE_LSB +: NUM_TXB]   = txe_q;
          rd_mux[ABORT_ACKNOWLEDGE_BIT_LSB +: NUM_TXB] = abort_acknowledge_bit_q;
        end
        OFS_TX_CTRL:
        begin
          rd_mux[ABORT_REQUEST_BIT_LSB +: NUM_TXB] = abort_request_bit_q;
          rd_mux[TXIE_LSB +: NUM_TXB]  = txie_q;
        end
        OFS_ACC_CTRL:
        begin
          rd_mux[MODE_LSB +: 2]  = mode_q;
          rd_mux[HIT_LSB +: 2]   = hit_q;
          rd_mux[LOOPBACK_BIT]   = loop_q;
        end
        OFS_PATTERN: rd_mux = pat_q;
        OFS_MASK:    rd_mux = msk_q;
        default:     rd_mux = '0;
      endcase
    end
    else if (is_fg)
    begin
      for (int k = 0; k < LANES; k++)
      begin
        idx = int'(word) * LANES + k;
        if (idx < BUF_BYTES)
          rd_mux[k*BYTE_W +: BYTE_W] = fg_q[idx]; // RULE_01
      end
    end
    else if (is_tx)
    begin
      if (word == LOCAL_PRIORITY_FIELD_WORD)
        rd_mux[BYTE_W-1:0] = local_priority_field_q[int'(tx_n)*BYTE_W +: BYTE_W];
      else
      begin
        for (int k = 0; k < LANES; k++)
        begin
          idx = int'(word) * LANES + k;
          if (idx < BUF_BYTES)
            rd_mux[k*BYTE_W +: BYTE_W] = txb_q[tx_n][idx];
        end
      end
    end
  end

  // ---------------- bus slave, one wait state per transfer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bus_q       <= BUS_IDLE;
      addr_q      <= '0;
      wr_q        <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= '0;
    end
    else
    begin
      unique case (bus_q)
        BUS_IDLE:
        begin
          if (acc_take)
          begin
            addr_q      <= haddr[7:0];
            wr_q        <= hwrite;
            bus_q       <= BUS_DATA;
            hreadyout_q <= 1'b0;
          end
        end
        BUS_DATA:
        begin
          hrdata_q    <= wr_q ? '0 : rd_mux;
          hreadyout_q <= 1'b1;
          bus_q       <= BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------- message storage
  always_ff @(posedge mclk)
  begin
    if (rx_wr_en && rx_wr.idx < BUF_BYTES)
      bg_q[rx_wr.idx] <= rx_wr.data; // RULE_06 RULE_08
    if (rx_copy)
      fg_q <= bg_q; // RULE_01 RULE_02
    for (int n = 0; n < NUM_TXB; n++)
    begin
      for (int b = 0; b < BUF_BYTES; b++)
      begin
        if (wr_txdata && tx_n == 2'(n) && b / LANES == int'(word))
          txb_q[n][b] <= hwdata[(b % LANES)*BYTE_W +: BYTE_W]; // RULE_12
      end
    end
  end

  // ---------------- receive flags and filter setup
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rxf_q   <= 1'b0;
      ovr_q   <= 1'b0;
      rxie_q  <= 1'b0;
      ovrie_q <= 1'b0;
      mode_q  <= FM_32;
      hit_q   <= '0;
      loop_q  <= 1'b0;
      pat_q   <= '0;
      msk_q   <= '0;
    end
    else
    begin
      // a new frame landing with the clear keeps the flag set
      rxf_q <= (rxf_q & ~rxf_clr) | rx_copy; // RULE_03 RULE_23 RULE_24
      ovr_q <= (ovr_q & ~ovr_clr) | ovr_set; // RULE_11 RULE_24
      if (rx_copy)
        hit_q <= hit_idx; // RULE_18
      if (wr_rxie)
      begin
        rxie_q  <= hwdata[RXF_BIT];
        ovrie_q <= hwdata[OVR_BIT];
      end
      if (wr_acc)
      begin
        mode_q <= hwdata[MODE_LSB +: 2]; // RULE_25
        loop_q <= hwdata[LOOPBACK_BIT];
      end
      if (wr_pat)
        pat_q <= hwdata;
      if (wr_msk)
        msk_q <= hwdata;
    end
  end

  // ---------------- transmit flags and scheduling
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      txe_q     <= '1;
      abort_acknowledge_bit_q   <= '0;
      abort_request_bit_q   <= '0;
      txie_q    <= '0;
      local_priority_field_q    <= '0;
      tx_busy_q <= 1'b0;
      tx_sel_q  <= '0;
    end
    else
    begin
      txe_q   <= (txe_q & ~txe_clr) | sent | abt_ok; // RULE_13 RULE_14 RULE_16
      abort_acknowledge_bit_q <= (abort_acknowledge_bit_q & ~txe_clr) | abt_ok; // RULE_16
      abort_request_bit_q <= (wr_txctrl ? hwdata[ABORT_REQUEST_BIT_LSB +: NUM_TXB] : abort_request_bit_q)
                 & ~sent & ~abt_ok & ~txe_q; // RULE_16
      if (wr_txctrl)
        txie_q <= hwdata[TXIE_LSB +: NUM_TXB];
      if (wr_txprio)
        local_priority_field_q[int'(tx_n)*BYTE_W +: BYTE_W] <= hwdata[BYTE_W-1:0]; // RULE_12
      if (tx_done || tx_fail)
        tx_busy_q <= 1'b0; // RULE_15
      else if (tx_arb && pick_any && !tx_busy_q)
      begin
        tx_busy_q <= 1'b1;
        tx_sel_q  <= pick_sel; // RULE_15
      end
    end
  end

  // ---------------- link-side and interrupt outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_pending_q <= 1'b0;
      tx_rd_data_q <= '0;
      rx_ack_en_q  <= 1'b0;
      rx_irq_q     <= 1'b0;
      tx_irq_q     <= 1'b0;
      err_irq_q    <= 1'b0;
    end
    else
    begin
      // transmit side never depends on receive buffer state
      tx_pending_q <= |ready_v; // RULE_11
      tx_rd_data_q <= (tx_rd_idx < BUF_BYTES) ? txb_q[tx_sel_q][tx_rd_idx] : '0;
      rx_ack_en_q  <= own_ok; // RULE_08 RULE_09
      rx_irq_q     <= rxf_q & rxie_q; // RULE_07 RULE_23
      tx_irq_q     <= |(txe_q & txie_q); // RULE_14
      err_irq_q    <= ovr_q & ovrie_q; // RULE_11
    end
  end

  assign hreadyout  = hreadyout_q;
  assign hrdata     = hrdata_q;
  assign hresp      = 1'b0;
  assign tx_pending = tx_pending_q;
  assign tx_sel     = tx_sel_q;
  assign tx_rd_data = tx_rd_data_q;
  assign rx_ack_en  = rx_ack_en_q;
  assign loopback   = loop_q;
  assign rx_irq     = rx_irq_q;
  assign tx_irq     = tx_irq_q;
  assign err_irq    = err_irq_q;

endmodule

// ===== cmbf_core_sva.sv
module cmbf_core_sva
  import cmbf_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       rx_eof,
  input wire logic       rx_own,
  input wire logic       tx_arb,
  input wire logic       tx_done,
  input wire logic       tx_fail,
  input wire logic [1:0] tx_sel,
  input wire logic       rx_ack_en,
  input wire logic       loopback,
  input wire logic       rx_irq,
  input wire logic       tx_irq,
  input wire logic       err_irq
);
  logic wr_q;
  wire  wr_take = hsel && htrans[1] && hready && hwrite;
  always_ff @(posedge mclk)
  begin
    wr_q <= wr_take;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_bus_wait;
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus wait state wrong");
  property p_own_no_ack;
    rx_own && !loopback |=> !rx_ack_en;
  endproperty
  a_own_no_ack: assert property (p_own_no_ack)
    else $error("own frame acknowledged");
  property p_ack_on;
    rst_n && (!rx_own || loopback) |=> rx_ack_en;
  endproperty
  a_ack_on: assert property (p_ack_on)
    else $error("acknowledge withheld");
  property p_sel_hold;
    !tx_arb |=> $stable(tx_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("buffer choice changed without arbitration");
  property p_rx_irq_cause;
    $rose(rx_irq) |-> $past(rx_eof, 2) || $past(wr_q, 2);
  endproperty
  a_rx_irq_cause: assert property (p_rx_irq_cause)
    else $error("receive interrupt without end of frame");
  property p_tx_irq_cause;
    $rose(tx_irq) |-> $past(tx_done, 2) || $past(tx_fail, 2) || $past(tx_fail, 3)
                      || $past(wr_q, 2) || $past(wr_q, 3);
  endproperty
  a_tx_irq_cause: assert property (p_tx_irq_cause)
    else $error("transmit interrupt without cause");
  property p_err_irq_cause;
    $rose(err_irq) |-> $past(rx_eof, 2) || $past(wr_q, 2);
  endproperty
  a_err_irq_cause: assert property (p_err_irq_cause)
    else $error("overrun interrupt without frame");
  property p_rx_irq_hold;
    $fell(rx_irq) |-> $past(wr_q, 2);
  endproperty
  a_rx_irq_hold: assert property (p_rx_irq_hold)
    else $error("receive interrupt dropped without write");
endmodule

bind cmbf_core cmbf_core_sva i_cmbf_core_sva (.mclk, .rst_n, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .rx_eof, .rx_own, .tx_arb, .tx_done, .tx_fail, .tx_sel, .rx_ack_en, .loopback,
  .rx_irq, .tx_irq, .err_irq);

// ===== cmbf_core_tb.sv
module cmbf_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cmbf_pkg::*;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, rx_wr_en, rx_eof, rx_own;
  logic tx_arb, tx_done, tx_fail, tx_pending, rx_ack_en, loopback, rx_irq, tx_irq, err_irq;
  logic [31:0] haddr, hwdata, hrdata, rd, pat, msk;
  logic [1:0]  htrans, tx_sel, sel, ex_sel;
  logic [2:0]  hsize, ex, rdy;
  logic [3:0]  tx_rd_idx;
  logic [7:0]  tx_rd_data, b0;
  logic [7:0]  d0 [3];
  logic [23:0] pr;
  logic [103:0] fr;
  cmbf_rx_wr_t rx_wr;
  integer errors, cmp_count, seed, i;

  cmbf_core i_cmbf_core (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_wr_en, .rx_wr, .rx_eof, .rx_own,
    .tx_arb, .tx_done, .tx_fail, .tx_rd_idx, .tx_pending, .tx_sel, .tx_rd_data, .rx_ack_en,
    .loopback, .rx_irq, .tx_irq, .err_irq);
  cmbf_can_model i_cmbf_can_model (.mclk, .tx_sel, .tx_rd_data, .rx_wr_en, .rx_wr, .rx_eof,
    .rx_own, .tx_arb, .tx_done, .tx_fail, .tx_rd_idx);

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // pattern byte k against frame byte j
  function automatic logic bm(input int k, input int j);
    return ((fr[8*j+:8] ^ pat[8*k+:8]) & ~msk[8*k+:8]) == 8'h00;
  endfunction
  function automatic logic [2:0] accept(input logic [1:0] md);
    logic [3:0] h;
    case (md)
      FM_32:   h = {3'h0, bm(0, 0) && bm(1, 1) && (!fr[11] || (bm(2, 2) && bm(3, 3)))};
      FM_16:   h = {2'h0, bm(2, 0) && bm(3, 1), bm(0, 0) && bm(1, 1)};
      FM_8:    h = {bm(3, 0), bm(2, 0), bm(1, 0), bm(0, 0)};
      default: h = 4'h0;
    endcase
    return h[0] ? 3'h4 : h[1] ? 3'h5 : h[2] ? 3'h6 : h[3] ? 3'h7 : 3'h0;
  endfunction
  function automatic logic [1:0] pick(input logic [2:0] r);
    logic [1:0] s;
    logic [7:0] best;
    s = 2'h3;
    best = 8'hff;
    for (int k = 2; k >= 0; k--)
      if (r[k] && pr[8*k+:8] <= best)
      begin
        s = k[1:0];
        best = pr[8*k+:8];
      end
    return s;
  endfunction

  initial
  begin
    #400us;
    errors++;
    tally_and_finish();
  end

  initial
  begin
    {errors, cmp_count, rst_n, hsel, htrans, hwrite, haddr, hwdata} = '0;
    seed  = 32'hcc8867f6;
    hsize = 3'h2;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    ahb(0, OFS_TX_FLAG, 0);
    chk(rd, 32'h7);
    ahb(0, OFS_RX_FLAG, 0);
    chk(rd, 32'h0);
    ahb(0, 8'h30, 0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    ahb(1, OFS_RX_IE, 32'h1);
    for (i = 0; i < 16; i++)
    begin
      pat = $random(seed);
      msk = (i < 4) ? 32'hffffffff : ($random(seed) | $random(seed));
      fr = {$random(seed), $random(seed), $random(seed), $random(seed)} >> 24;
      if (i[2])
        fr[31:0] = pat;
      ex = accept(i[1:0]);
      ahb(1, OFS_ACC_CTRL, {30'h0, i[1:0]});
      ahb(1, OFS_PATTERN, pat);
      ahb(1, OFS_MASK, msk);
      i_cmbf_can_model.rx_frame(fr, 0);
      ahb(0, OFS_RX_FLAG, 0);
      chk(rd[0], ex[2]);
      chk(rx_irq, ex[2]);
      if (ex[2])
      begin
        ahb(0, OFS_ACC_CTRL, 0);
        chk(rd[5:4], ex[1:0]);
        ahb(0, 8'h40, 0);
        chk(rd, fr[31:0]);
        ahb(0, 8'h4c, 0);
        chk(rd, {24'h0, fr[103:96]});
      end
      ahb(1, OFS_RX_FLAG, 32'h1);
    end
    ahb(1, OFS_ACC_CTRL, 32'h0);
    ahb(1, OFS_MASK, 32'hffffffff);
    ahb(1, OFS_RX_IE, 32'h3);
    i_cmbf_can_model.rx_frame(fr, 0);
    i_cmbf_can_model.rx_frame(~fr, 0);
    ahb(0, OFS_RX_FLAG, 0);
    chk(rd, 32'h3);
    chk(err_irq, 1'b1);
    ahb(0, 8'h40, 0);
    chk(rd, fr[31:0]);
    // transmit while both receive flags stay set
    pr = $random(seed);
    pr[23:16] = pr[7:0];
    for (i = 0; i < 3; i++)
    begin
      rd = $random(seed);
      d0[i] = rd[7:0];
      ahb(1, 8'h80 + 8'(32 * i), rd);
      ahb(1, 8'h90 + 8'(32 * i), {24'h0, pr[8*i+:8]});
    end
    ahb(1, OFS_TX_CTRL, 32'h70);
    ahb(1, OFS_TX_FLAG, 32'h7);
    ahb(0, OFS_TX_FLAG, 0);
    chk(rd, 32'h0);
    chk(tx_pending, 1'b1);
    chk(tx_irq, 1'b0);
    rdy = 3'h7;
    for (i = 0; i < 2; i++)
    begin
      ex_sel = pick(rdy);
      i_cmbf_can_model.tx_run(1'b0, $random(seed) & 3, sel, b0);
      chk(sel, ex_sel);
      i_cmbf_can_model.tx_run(1'b1, $random(seed) & 3, sel, b0);
      chk(sel, ex_sel);
      chk(b0, d0[ex_sel]);
      rdy[ex_sel] = 1'b0;
      ahb(0, OFS_TX_FLAG, 0);
      chk(rd, {29'h0, ~rdy});
      chk(tx_irq, 1'b1);
    end
    ex_sel = pick(rdy);
    ahb(1, OFS_TX_CTRL, 32'h70 | (32'h1 << ex_sel));
    ahb(1, OFS_TX_CTRL, 32'h0);
    ahb(0, OFS_TX_FLAG, 0);
    chk(rd, 32'h7 | (32'h10 << ex_sel));
    chk(tx_pending, 1'b0);
    chk(tx_irq, 1'b0);
    ahb(1, OFS_RX_FLAG, 32'h3);
    ahb(0, OFS_RX_FLAG, 0);
    chk(rd, 32'h0);
    chk(err_irq, 1'b0);
    i_cmbf_can_model.rx_frame(fr, 13);
    ahb(0, OFS_RX_FLAG, 0);
    chk(rd[0], 1'b0);
    i_cmbf_can_model.rx_frame(fr, 4);
    ahb(0, OFS_RX_FLAG, 0);
    chk(rd[0], 1'b1);
    ahb(1, OFS_RX_FLAG, 32'h1);
    ahb(1, OFS_ACC_CTRL, 32'h100);
    chk(loopback, 1'b1);
    i_cmbf_can_model.rx_frame(~fr, 13);
    ahb(0, 8'h40, 0);
    chk(rd, ~fr[31:0]);
    chk(rx_irq, 1'b1);
    tally_and_finish();
  end
endmodule

// ===== cmbf_local_priority_field_pick.sv
module cmbf_local_priority_field_pick
  import cmbf_pkg::*;
(
  input  wire logic [NUM_TXB-1:0]        ready,
  input  wire logic [NUM_TXB*BYTE_W-1:0] local_priority_field,
  output logic      [1:0]                sel,
  output logic                           any
);
  cmbf_byte_t best;

  // lowest value wins, ties go to the lower buffer
  always_comb
  begin
    best = '1;
    sel  = '0;
    any  = 1'b0;
    for (int i = 0; i < NUM_TXB; i++)
    begin
      if (ready[i] && (!any || local_priority_field[i*BYTE_W +: BYTE_W] < best))
      begin
        best = local_priority_field[i*BYTE_W +: BYTE_W];
        sel  = 2'(i);
        any  = 1'b1;
      end
    end
  end
endmodule

// ===== cmbf_pkg.sv
package cmbf_pkg;

  localparam int BUF_BYTES = 13;
  localparam int NUM_TXB   = 3;
  localparam int BYTE_W    = 8;
  localparam int LANES     = 4;
  localparam int NUM_FILT  = 4;

  // control register byte offsets
  localparam logic [7:0] OFS_RX_FLAG  = 8'h00;
  localparam logic [7:0] OFS_RX_IE    = 8'h04;
  localparam logic [7:0] OFS_TX_FLAG  = 8'h08;
  localparam logic [7:0] OFS_TX_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_ACC_CTRL = 8'h10;
  localparam logic [7:0] OFS_PATTERN  = 8'h14;
  localparam logic [7:0] OFS_MASK     = 8'h18;

  // address regions, selected by haddr[7:5]
  localparam logic [2:0] REG_CTRL  = 3'h0;
  localparam logic [2:0] REG_RX_FG = 3'h2;
  localparam logic [1:0] TX_NONE   = 2'h3;
  localparam logic [2:0] LOCAL_PRIORITY_FIELD_WORD = 3'h4;
  localparam logic [2:0] DATA_WORDS = 3'h4;

  // field positions
  localparam int RXF_BIT      = 0;
  localparam int OVR_BIT      = 1;
  localparam int TXE_LSB      = 0;
  localparam int ABORT_ACKNOWLEDGE_BIT_LSB    = 4;
  localparam int ABORT_REQUEST_BIT_LSB    = 0;
  localparam int TXIE_LSB     = 4;
  localparam int MODE_LSB     = 0;
  localparam int HIT_LSB      = 4;
  localparam int LOOPBACK_BIT = 8;
  localparam int IDE_BIT      = 3;

  // filter mode codes
  localparam logic [1:0] FM_32     = 2'h0;
  localparam logic [1:0] FM_16     = 2'h1;
  localparam logic [1:0] FM_8      = 2'h2;
  localparam logic [1:0] FM_CLOSED = 2'h3;

  typedef logic [7:0] cmbf_byte_t;

  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] data;
  } cmbf_rx_wr_t;

  typedef enum logic {BUS_IDLE, BUS_DATA} cmbf_bus_state_t;

endpackage
